// [logic/igc_ctrl.sv]
// Interrupt gating, priority arbitration and control registers
//
// Function
// - Enable flag zero blocks maskable requests
// - Accepting a request clears enable flag
// - Stack select zero picks interrupt stack
// - Hardware accept or low software number clears select
// - Three-bit processor priority level, 0 to 7
// - Request passes only above processor level
// - Reserved bits written zero, read as zero
// - Control registers six bits wide, all bits reset to zero
// - One control register serves two sources
`timescale 1ns/1ps
`default_nettype none

module igc_ctrl (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Peripheral request events, one-cycle pulses
  input  wire logic [42:0] src_a_i,
  input  wire logic [42:0] src_b_i,
  // Core side
  input  wire logic        irq_ack_i,
  input  wire logic        swint_i,
  input  wire logic [5:0]  swint_num_i,
  output logic             irq_req_o,
  output logic [5:0]       irq_slot_o,
  output logic [2:0]       irq_lvl_o,
  output logic             int_enable_o,
  output logic             user_stack_sel_o,
  output logic [2:0]       processor_priority_level_o,
  // Summary interrupt
  output logic             irq_o
);

  localparam int N = igc_pkg::IC_N;

  // ****************************************************************
  // State
  // ****************************************************************
  igc_pkg::igc_ic_t    ic [N];
  igc_pkg::igc_flags_t flags;
  logic [N-1:0]        src_sel;
  logic [igc_pkg::ST_W-1:0] stat;
  logic [igc_pkg::ST_W-1:0] mask;

  // Bus data-phase capture
  logic       dp_write;
  logic [7:0] dp_idx;
  logic       dp_valid;

  // Decode and arbitration results
  logic       ap_valid;
  logic [7:0] ap_idx;
  logic       ap_hit_ic;
  logic [5:0] ap_slot;
  logic       ap_mapped;
  logic       wr_hit_ic;
  logic [5:0] wr_slot;
  logic       wr_en;
  logic [N-1:0] ev;
  logic       best_ok;
  logic [5:0] best_slot;
  logic [2:0] best_lvl;
  logic       accept;
  logic       swint_low;
  logic [31:0] next_rdata;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Address phase taken when the bus is ready and a transfer is active
  assign ap_valid = hsel_i & hready_i & htrans_i[1];
  assign ap_idx   = haddr_i[9:2];
  assign wr_en    = dp_valid & dp_write;

  // Map an index onto a control register slot
  always_comb begin
    ap_hit_ic = 1'b0;
    ap_slot   = 6'h0;
    wr_hit_ic = 1'b0;
    wr_slot   = 6'h0;
    for (int k = 0; k < N; k++) begin
      if (igc_pkg::IC_IDX[k] == ap_idx) begin
        ap_hit_ic = 1'b1;
        ap_slot   = 6'(k);
      end
      if (igc_pkg::IC_IDX[k] == dp_idx) begin
        wr_hit_ic = 1'b1;
        wr_slot   = 6'(k);
      end
    end
  end

  // Known location check; upper address bits must be zero
  always_comb begin
    ap_mapped = 1'b0;
    if (haddr_i[31:10] == 22'h0) begin
      case (ap_idx)
        igc_pkg::IDX_FLAGS,
        igc_pkg::IDX_IRQ_STAT,
        igc_pkg::IDX_IRQ_MASK,
        igc_pkg::IDX_SEL_LO,
        igc_pkg::IDX_SEL_HI: ap_mapped = 1'b1;
        default:             ap_mapped = ap_hit_ic;
      endcase
    end
  end

  // ****************************************************************
  // Request sources and arbitration
  // ****************************************************************
  // Shared slots pick their source through the select bits
  always_comb begin
    for (int k = 0; k < N; k++) begin
      ev[k] = (igc_pkg::IC_SHARED[k] & src_sel[k]) ? src_b_i[k] : src_a_i[k];
    end
  end

  // Highest level wins, lowest slot breaks a tie
  always_comb begin
    best_ok   = 1'b0;
    best_slot = 6'h0;
    best_lvl  = 3'h0;
    for (int k = 0; k < N; k++) begin
      if (ic[k].req && ic[k].lvl > flags.processor_priority_level) begin
        if (!best_ok || ic[k].lvl > best_lvl) begin
          best_ok   = 1'b1;
          best_slot = 6'(k);
          best_lvl  = ic[k].lvl;
        end
      end
    end
  end

  // Core takes the offered request
  assign accept    = irq_ack_i & irq_req_o;
  assign swint_low = swint_i & (swint_num_i <= igc_pkg::SWINT_U_MAX);

  // ****************************************************************
  // Interrupt control registers
  // ****************************************************************
  // Source event sets the request flag and wins over clears
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int k = 0; k < N; k++) begin
        ic[k] <= '0;
      end
    end else begin
      for (int k = 0; k < N; k++) begin
        if (wr_en && wr_hit_ic && wr_slot == 6'(k)) begin
          ic[k].lvl <= hwdata_i[igc_pkg::IC_LVL_LSB +: 3];
          ic[k].ext <= hwdata_i[igc_pkg::IC_EXT_LSB +: 2];
          ic[k].req <= hwdata_i[igc_pkg::IC_REQ_BIT] | ev[k];
        end else if (accept && irq_slot_o == 6'(k)) begin
          ic[k].req <= ev[k];
        end else if (ev[k]) begin
          ic[k].req <= 1'b1;
        end
      end
    end
  end

  // Source select bits for shared slots
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      src_sel <= '0;
    end else if (wr_en && dp_idx == igc_pkg::IDX_SEL_LO) begin
      src_sel[31:0] <= hwdata_i & igc_pkg::IC_SHARED[31:0];
    end else if (wr_en && dp_idx == igc_pkg::IDX_SEL_HI) begin
      src_sel[N-1:32] <= hwdata_i[N-33:0] & igc_pkg::IC_SHARED[N-1:32];
    end
  end

  // ****************************************************************
  // Processor flags
  // ****************************************************************
  // Enable flag: cleared by any accept or software interrupt, else software write
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flags.i <= igc_pkg::I_RESET;
    end else if (accept || swint_i) begin
      flags.i <= 1'b0;
    end else if (wr_en && dp_idx == igc_pkg::IDX_FLAGS) begin
      flags.i <= hwdata_i[igc_pkg::FL_I_BIT];
    end
  end

  // Stack select flag
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flags.u <= igc_pkg::U_RESET;
    end else if (accept || swint_low) begin
      flags.u <= 1'b0;
    end else if (wr_en && dp_idx == igc_pkg::IDX_FLAGS) begin
      flags.u <= hwdata_i[igc_pkg::FL_U_BIT];
    end
  end

  // Priority level: raised to the accepted level
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flags.processor_priority_level <= igc_pkg::IPL_RESET;
    end else if (accept) begin
      flags.processor_priority_level <= irq_lvl_o;
    end else if (wr_en && dp_idx == igc_pkg::IDX_FLAGS) begin
      flags.processor_priority_level <= hwdata_i[igc_pkg::FL_IPL_LSB +: 3];
    end
  end

  // ****************************************************************
  // Request to the core
  // ****************************************************************
  // Offer drops in the cycle after an accept
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_req_o  <= 1'b0;
      irq_slot_o <= 6'h0;
      irq_lvl_o  <= 3'h0;
    end else if (accept) begin
      irq_req_o <= 1'b0;
    end else begin
      irq_req_o  <= flags.i & best_ok;
      irq_slot_o <= best_slot;
      irq_lvl_o  <= best_lvl;
    end
  end

  // Flag copies for the core
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      int_enable_o               <= igc_pkg::I_RESET;
      user_stack_sel_o           <= igc_pkg::U_RESET;
      processor_priority_level_o <= igc_pkg::IPL_RESET;
    end else begin
      int_enable_o               <= flags.i;
      user_stack_sel_o           <= flags.u;
      processor_priority_level_o <= flags.processor_priority_level;
    end
  end

  // ****************************************************************
  // Event status, mask and summary interrupt
  // ****************************************************************
  // Sticky status, write one to clear, set wins
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      stat <= '0;
    end else begin
      if (wr_en && dp_idx == igc_pkg::IDX_IRQ_STAT) begin
        stat <= stat & ~hwdata_i[igc_pkg::ST_W-1:0];
      end
      if (accept) begin
        stat[igc_pkg::ST_ACCEPT] <= 1'b1;
      end
      if (swint_i) begin
        stat[igc_pkg::ST_SWINT] <= 1'b1;
      end
      if (ap_valid && !ap_mapped) begin
        stat[igc_pkg::ST_BADADDR] <= 1'b1;
      end
    end
  end

  // Mask register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask <= '0;
    end else if (wr_en && dp_idx == igc_pkg::IDX_IRQ_MASK) begin
      mask <= hwdata_i[igc_pkg::ST_W-1:0];
    end
  end

  // Summary output
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat & mask);
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Read data chosen in the address phase; reserved bits read zero
  always_comb begin
    next_rdata = 32'h0;
    if (ap_hit_ic) begin
      next_rdata[5:0] = ic[ap_slot];
    end else begin
      case (ap_idx)
        igc_pkg::IDX_FLAGS: begin
          next_rdata[igc_pkg::FL_I_BIT]        = flags.i;
          next_rdata[igc_pkg::FL_U_BIT]        = flags.u;
          next_rdata[igc_pkg::FL_IPL_LSB +: 3] = flags.processor_priority_level;
        end
        igc_pkg::IDX_IRQ_STAT: next_rdata[igc_pkg::ST_W-1:0] = stat;
        igc_pkg::IDX_IRQ_MASK: next_rdata[igc_pkg::ST_W-1:0] = mask;
        igc_pkg::IDX_SEL_LO:   next_rdata = src_sel[31:0];
        igc_pkg::IDX_SEL_HI:   next_rdata[N-33:0] = src_sel[N-1:32];
        default:               next_rdata = 32'h0;
      endcase
      if (!ap_mapped) begin
        next_rdata = 32'h0;
      end
    end
  end

  // Capture the address phase for the data phase
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx   <= 8'h0;
    end else if (hready_i) begin
      dp_valid <= ap_valid & ap_mapped;
      dp_write <= hwrite_i;
      dp_idx   <= ap_idx;
    end
  end

  // Zero-wait answer, always OKAY
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o     <= igc_pkg::HRESP_OKAY;
      hrdata_o    <= 32'h0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= igc_pkg::HRESP_OKAY;
      if (ap_valid && !hwrite_i) begin
        hrdata_o <= next_rdata;
      end
    end
  end

endmodule

`default_nettype wire

// [logic/igc_pkg.sv]
// Constants, register map and types of the interrupt gating and control block
package igc_pkg;

  // ****************************************************************
  // Interrupt control register map (register indices)
  // ****************************************************************
  localparam int IC_N = 43;
  localparam logic [7:0] IC_IDX [IC_N] = '{
    8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49,
    8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h51,
    8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59,
    8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h69, 8'h6a,
    8'h6b, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h71, 8'h72,
    8'h73, 8'h7b, 8'h7c};
  // External pin source slots; bits 5:4 reset to zero in every slot
  localparam logic [IC_N-1:0] IC_EXT_PIN = 43'h000_3800_00c7;
  // Slots shared by two sources
  localparam logic [IC_N-1:0] IC_SHARED  = 43'h0db_0000_00f0;

  // Control and status registers (register indices)
  localparam logic [7:0] IDX_FLAGS    = 8'h80;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h81;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h82;
  localparam logic [7:0] IDX_SEL_LO   = 8'h83;
  localparam logic [7:0] IDX_SEL_HI   = 8'h84;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int IC_LVL_LSB = 0;
  localparam int IC_REQ_BIT = 3;
  localparam int IC_EXT_LSB = 4;
  localparam int FL_I_BIT   = 0;
  localparam int FL_U_BIT   = 1;
  localparam int FL_IPL_LSB = 4;
  localparam int ST_ACCEPT  = 0;
  localparam int ST_SWINT   = 1;
  localparam int ST_BADADDR = 2;
  localparam int ST_W       = 3;
  localparam logic [2:0] IPL_RESET  = 3'h0;
  localparam logic       I_RESET    = 1'b0;
  localparam logic       U_RESET    = 1'b0;
  localparam logic [5:0] SWINT_U_MAX = 6'h1f;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] ext;
    logic       req;
    logic [2:0] lvl;
  } igc_ic_t;

  typedef struct packed {
    logic       i;
    logic       u;
    logic [2:0] processor_priority_level;
  } igc_flags_t;

endpackage

// [verif/igc_ctrl_assertions.sv]
// Checker of request gating and flag behaviour at the block ports
`timescale 1ns/1ps
`default_nettype none

module igc_ctrl_checker (
  input wire logic       clock_i,
  input wire logic       srst_i,
  input wire logic       irq_ack_i,
  input wire logic       swint_i,
  input wire logic [5:0] swint_num_i,
  input wire logic       irq_req_o,
  input wire logic [2:0] irq_lvl_o,
  input wire logic       int_enable_o,
  input wire logic       user_stack_sel_o,
  input wire logic [2:0] processor_priority_level_o
);
  // ****************************************************************
  // Offer, accept, software interrupt and reset properties
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic acc;
  // Offer taken by the core
  assign acc = irq_req_o && irq_ack_i;

  AST_GATE_EN: assert property (irq_req_o |-> int_enable_o)
    else $error("request offered while disabled");
  AST_ACK_DROP: assert property (acc |=> !irq_req_o [*2])
    else $error("offer not withdrawn after accept");
  AST_ACK_FLAGS: assert property (acc |-> ##2 !int_enable_o && !user_stack_sel_o)
    else $error("flags not cleared after accept");
  AST_ACK_LVL: assert property (acc |-> ##2 processor_priority_level_o == $past(irq_lvl_o, 2))
    else $error("processor level not taken from accepted request");
  AST_ABOVE_LVL: assert property (irq_req_o |-> irq_lvl_o > processor_priority_level_o)
    else $error("offer not above processor level");
  AST_SW_LOW: assert property (swint_i && swint_num_i <= 6'h1f |-> ##2 !user_stack_sel_o && !int_enable_o)
    else $error("low software number left flags set");
  AST_SW_HIGH: assert property (swint_i && swint_num_i > 6'h1f && user_stack_sel_o && !irq_req_o
                                && !$past(irq_ack_i) |-> ##2 user_stack_sel_o)
    else $error("high software number cleared stack select");
  AST_RST_VAL: assert property (disable iff (1'b0) srst_i [*2] |-> !irq_req_o && !int_enable_o
                                && !user_stack_sel_o && processor_priority_level_o == 3'h0)
    else $error("flag copies not cleared by reset");
endmodule

bind igc_ctrl igc_ctrl_checker i_chk (
  .clock_i(clock_i),
  .srst_i(srst_i),
  .irq_ack_i(irq_ack_i),
  .swint_i(swint_i),
  .swint_num_i(swint_num_i),
  .irq_req_o(irq_req_o),
  .irq_lvl_o(irq_lvl_o),
  .int_enable_o(int_enable_o),
  .user_stack_sel_o(user_stack_sel_o),
  .processor_priority_level_o(processor_priority_level_o)
);
`default_nettype wire

// [verif/igc_ctrl_tb_top.sv]
// Bench of the interrupt gating and control block
`timescale 1ns/1ps
`default_nettype none

module igc_ctrl_tb_top;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = igc_pkg::HTRANS_IDLE;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = '0;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [42:0] src_a;
  logic [42:0] src_b;
  logic        ack;
  logic        swint;
  logic [5:0]  swint_num;
  logic        irq_req;
  logic [5:0]  irq_slot;
  logic        irq;
  logic [31:0] rd;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #10 clock_i = ~clock_i;

  igc_ctrl i_dut (.clock_i(clock_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .src_a_i(src_a), .src_b_i(src_b), .irq_ack_i(ack), .swint_i(swint),
    .swint_num_i(swint_num), .irq_req_o(irq_req), .irq_slot_o(irq_slot), .irq_lvl_o(), .int_enable_o(),
    .user_stack_sel_o(), .processor_priority_level_o(), .irq_o(irq));
  igc_far_end i_far (.clock_i(clock_i), .irq_req_i(irq_req), .irq_slot_i(irq_slot), .src_a_o(src_a),
    .src_b_o(src_b), .irq_ack_o(ack), .swint_o(swint), .swint_num_o(swint_num));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Single word transfer, each phase held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= igc_pkg::HTRANS_NONSEQ;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clock_i); while (hready !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= igc_pkg::HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge clock_i); while (hready !== 1'b1 && ++n < 100);
    rd = hrdata;
    chk(32'(hresp), 32'(igc_pkg::HRESP_OKAY));
    if (n >= 50) chk(32'(n), 32'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_acc(input int n);
    int k;
    for (k = 0; k < 100 && i_far.acc_q.size() < n; k++) @(posedge clock_i);
    chk(32'(i_far.acc_q.size()), 32'(n));
  endtask

  // Hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      end_of_test();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    rdc(igc_pkg::IDX_FLAGS, 32'h0);
    for (int i = 0; i < igc_pkg::IC_N; i++) begin
      rdc(igc_pkg::IC_IDX[i], 32'h0);
      wr(igc_pkg::IC_IDX[i], 32'h30 | 32'(i % 8));
      rdc(igc_pkg::IC_IDX[i], 32'h30 | 32'(i % 8));
      wr(igc_pkg::IC_IDX[i], 32'h0);
    end
    rdc(8'h60, 32'h0);
    rdc(igc_pkg::IDX_IRQ_STAT, 32'h4);
    chk(irq, 32'h0);
    wr(igc_pkg::IDX_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clock_i);
    chk(irq, 32'h1);
    wr(igc_pkg::IDX_IRQ_STAT, 32'h4);
    repeat (2) @(posedge clock_i);
    chk(irq, 32'h0);
    $display("test registers done");
    wr(8'h44, 32'h3);
    wr(8'h4c, 32'h5);
    wr(8'h56, 32'h5);
    i_far.pulse(2, 1'b0);
    i_far.pulse(10, 1'b0);
    i_far.pulse(20, 1'b0);
    rdc(8'h4c, 32'hd);
    repeat (4) @(posedge clock_i);
    chk(irq_req, 32'h0);
    wr(igc_pkg::IDX_FLAGS, 32'h53);
    repeat (4) @(posedge clock_i);
    chk(irq_req, 32'h0);
    i_far.ack_dly = 3;
    wr(igc_pkg::IDX_FLAGS, 32'h43);
    wait_acc(1);
    rdc(igc_pkg::IDX_FLAGS, 32'h50);
    rdc(8'h4c, 32'h5);
    rdc(igc_pkg::IDX_IRQ_STAT, 32'h1);
    wr(igc_pkg::IDX_FLAGS, 32'h1);
    wait_acc(2);
    wr(igc_pkg::IDX_FLAGS, 32'h1);
    wait_acc(3);
    chk(i_far.acc_q[0], 32'd10);
    chk(i_far.acc_q[1], 32'd20);
    chk(i_far.acc_q[2], 32'd2);
    $display("test arbitration done");
    wr(igc_pkg::IDX_SEL_LO, 32'hffffffff);
    rdc(igc_pkg::IDX_SEL_LO, igc_pkg::IC_SHARED[31:0]);
    wr(8'h46, 32'h6);
    i_far.pulse(4, 1'b1);
    rdc(8'h46, 32'he);
    wr(igc_pkg::IDX_FLAGS, 32'h1);
    wait_acc(4);
    chk(i_far.acc_q[3], 32'd4);
    $display("test shared slot done");
    wr(igc_pkg::IDX_IRQ_STAT, 32'h7);
    wr(igc_pkg::IDX_FLAGS, 32'h3);
    i_far.swi(6'h20);
    rdc(igc_pkg::IDX_FLAGS, 32'h2);
    rdc(igc_pkg::IDX_IRQ_STAT, 32'h2);
    wr(igc_pkg::IDX_FLAGS, 32'h3);
    i_far.swi(6'h1f);
    rdc(igc_pkg::IDX_FLAGS, 32'h0);
    $display("test software interrupt done");
    end_of_test();
  end
endmodule
`default_nettype wire

// [verif/igc_far_end.sv]
// Model of the peripheral sources and the instruction core
`timescale 1ns/1ps
`default_nettype none

module igc_far_end (
  input  wire logic        clock_i,
  input  wire logic        irq_req_i,
  input  wire logic [5:0]  irq_slot_i,
  output logic [42:0]      src_a_o,
  output logic [42:0]      src_b_o,
  output logic             irq_ack_o,
  output logic             swint_o,
  output logic [5:0]       swint_num_o
);
  int         ack_dly = 0;
  int         wait_n = 0;
  logic [5:0] acc_q[$];

  // Idle lines at time zero
  initial begin
    src_a_o = '0;
    src_b_o = '0;
    irq_ack_o = 1'b0;
    swint_o = 1'b0;
    swint_num_o = 6'h2a;
  end

  // One-cycle event from a primary or alternate source
  task automatic pulse(input int k, input bit alt);
    @(posedge clock_i);
    if (alt) src_b_o[k] <= 1'b1;
    else src_a_o[k] <= 1'b1;
    @(posedge clock_i);
    src_a_o <= '0;
    src_b_o <= '0;
  endtask

  // Software interrupt, number line scrambled when not valid
  task automatic swi(input logic [5:0] n);
    @(posedge clock_i);
    swint_o <= 1'b1;
    swint_num_o <= n;
    @(posedge clock_i);
    swint_o <= 1'b0;
    swint_num_o <= ~n;
  endtask

  // Core accepts an offer after ack_dly cycles, never when zero
  always @(posedge clock_i) begin
    irq_ack_o <= 1'b0;
    // Slot logged at the edge where the block sees ack with its offer up
    if (irq_ack_o && irq_req_i) begin
      acc_q.push_back(irq_slot_i);
    end
    if (irq_req_i && !irq_ack_o && ack_dly > 0) begin
      wait_n <= wait_n + 1;
      if (wait_n + 1 >= ack_dly) begin
        irq_ack_o <= 1'b1;
        wait_n <= 0;
      end
    end else wait_n <= 0;
  end
endmodule
`default_nettype wire
